// ### hdl/fpl_regs.svh
// Register offsets, field positions and timing counts of the front panel logic
`ifndef FPL_REGS_SVH
`define FPL_REGS_SVH
`define FPL_OFS_CTRL      8'h00
`define FPL_OFS_CMD       8'h04
`define FPL_OFS_STATUS    8'h08
`define FPL_OFS_INT_STAT  8'h0C
`define FPL_OFS_INT_MASK  8'h10
`define FPL_CMD_RUN_BIT   0
`define FPL_CMD_STOP_BIT  1
`define FPL_CTRL_RST      8'h00
`define FPL_MASK_RST      3'h0
`define FPL_RESP_OKAY     2'h0
`define FPL_RESP_DECERR   2'h3
`define FPL_CLK_NS        25
`define FPL_BLINK_NS      500000000
`define FPL_STRETCH_NS    50000000
`define FPL_SYNC_WAIT     2'h2
`endif

// ### hdl/fpl_pkg.sv
// Types shared by the front panel logic
package fpl_pkg;
    typedef enum logic [1:0] {
        FPL_BUS_ABSENT  = 2'h0,
        FPL_BUS_STARTUP = 2'h1,
        FPL_BUS_OPER    = 2'h2,
        FPL_BUS_RSVD    = 2'h3
    } fpl_bus_state_t;

    typedef enum logic [2:0] {
        FPL_ST_WAIT   = 3'b001,
        FPL_ST_INIT   = 3'b010,
        FPL_ST_NORMAL = 3'b100
    } fpl_state_t;

    typedef struct packed {
        logic [2:0]     rsvd;
        fpl_bus_state_t bus_state;
        logic           card_busy;
        logic           sys_error;
        logic           app_loaded;
    } fpl_ctrl_t;

    typedef struct packed {
        logic err_rise;
        logic dev_reset;
        logic mode_chg;
    } fpl_irq_t;

    typedef enum logic [2:0] {
        FPL_SEL_CTRL  = 3'h0,
        FPL_SEL_CMD   = 3'h1,
        FPL_SEL_STAT  = 3'h2,
        FPL_SEL_ISTAT = 3'h3,
        FPL_SEL_IMASK = 3'h4,
        FPL_SEL_NONE  = 3'h7
    } fpl_sel_t;
endpackage

// ### hdl/fpl_front_panel.sv
// Front panel status, mode and indicator logic with AXI4-Lite registers
//
// Function
// R1 - At power-on the run or stop mode is taken from the sampled mode switch.
// R2 - After power-on a remote run or stop command sets the mode whatever the switch says.
// R3 - Stop mode with the reset bit switch on at power-on launches the device reset.
// R4 - The blue power lamp is lit only when the supply has started normally.
// R5 - The red alarm lamp is lit steadily while a system error is present.
// R6 - Run and stop lamps show operating, stopped, or both dark with no application.
// R7 - The error lamp flashes half a second on and off during a system error.
// R8 - The card lamp is lit while a card access is in progress.
// R9 - The serial transmit lamp flashes while characters are sent.
// R10 - The serial receive lamp flashes while characters arrive.
// R11 - The fieldbus lamp is steady when operational, flashes on start-up, dark when absent.
// R12 - The port lamp is steady with traffic, flashes with idle link, dark without link.
// R13 - Each counter phase lamp follows its live input level.
// R14 - Sixteen lamps show input or output contacts as picked by the display switch.
// R15 - Activity flashes are stretched to a visible minimum on and off time.
`timescale 1ns/1ps
`include "fpl_regs.svh"
module fpl_front_panel #(
    parameter int unsigned BLINK_CYC   = `FPL_BLINK_NS / `FPL_CLK_NS,
    parameter int unsigned STRETCH_CYC = `FPL_STRETCH_NS / `FPL_CLK_NS
) (
    input  wire logic        MCLK_I,
    input  wire logic        RESET_I,
    input  wire logic [7:0]  AWADDR_I,
    input  wire logic        AWVALID_I,
    output logic             AWREADY_O,
    input  wire logic [31:0] WDATA_I,
    input  wire logic [3:0]  WSTRB_I,
    input  wire logic        WVALID_I,
    output logic             WREADY_O,
    output logic [1:0]       BRESP_O,
    output logic             BVALID_O,
    input  wire logic        BREADY_I,
    input  wire logic [7:0]  ARADDR_I,
    input  wire logic        ARVALID_I,
    output logic             ARREADY_O,
    output logic [31:0]      RDATA_O,
    output logic [1:0]       RRESP_O,
    output logic             RVALID_O,
    input  wire logic        RREADY_I,
    input  wire logic        MODE_RUN_SW_I,
    input  wire logic        RESET_BIT_SWITCH_I,
    input  wire logic        DISP_SEL_OUT_I,
    input  wire logic        POWER_GOOD_I,
    input  wire logic        SER_TX_I,
    input  wire logic        SER_RX_I,
    input  wire logic        PHYSICAL_LINK_UP_I,
    input  wire logic        PHY_TRAFFIC_I,
    input  wire logic [5:0]  CNT_PHASE_I,
    input  wire logic [15:0] INPUT_CONTACTS_I,
    input  wire logic [15:0] OUTPUT_CONTACTS_I,
    output logic             POWER_LED_O,
    output logic             ALARM_LED_O,
    output logic             RUN_LED_O,
    output logic             STOP_LED_O,
    output logic             ERROR_LED_O,
    output logic             CARD_ACCESS_INDICATOR_O,
    output logic             SERIAL_TX_INDICATOR_O,
    output logic             SERIAL_RX_INDICATOR_O,
    output logic             FIELDBUS_LINK_INDICATOR_O,
    output logic             PORT_LINK_ACTIVITY_INDICATOR_O,
    output logic [5:0]       CNT_PHASE_LED_O,
    output logic [15:0]      CONTACT_LED_O,
    output logic             DEVICE_RESET_O,
    output logic             IRQ_O
);
    localparam int unsigned NPIN = 46;

    function automatic fpl_pkg::fpl_sel_t dec(input logic [7:0] a);
        case (a)
            `FPL_OFS_CTRL:     dec = fpl_pkg::FPL_SEL_CTRL;
            `FPL_OFS_CMD:      dec = fpl_pkg::FPL_SEL_CMD;
            `FPL_OFS_STATUS:   dec = fpl_pkg::FPL_SEL_STAT;
            `FPL_OFS_INT_STAT: dec = fpl_pkg::FPL_SEL_ISTAT;
            `FPL_OFS_INT_MASK: dec = fpl_pkg::FPL_SEL_IMASK;
            default:           dec = fpl_pkg::FPL_SEL_NONE;
        endcase
    endfunction

    // Pin synchronisers
    logic [NPIN-1:0] sync1_reg;
    logic [NPIN-1:0] sync2_reg;
    wire  [NPIN-1:0] pins = {OUTPUT_CONTACTS_I, INPUT_CONTACTS_I, CNT_PHASE_I,
                             PHY_TRAFFIC_I, PHYSICAL_LINK_UP_I, SER_RX_I, SER_TX_I,
                             POWER_GOOD_I, DISP_SEL_OUT_I, RESET_BIT_SWITCH_I,
                             MODE_RUN_SW_I};
    always_ff @(posedge MCLK_I)
    begin
        sync1_reg <= pins;
        sync2_reg <= sync1_reg;
    end
    wire        mode_sw   = sync2_reg[0];
    wire        rstbit_sw = sync2_reg[1];
    wire        disp_out  = sync2_reg[2];
    wire        pwr_ok    = sync2_reg[3];
    wire [2:0]  act_lvl   = {sync2_reg[7], sync2_reg[5:4]};
    wire        link_up   = sync2_reg[6];
    wire [5:0]  phase_s   = sync2_reg[13:8];
    wire [15:0] in_c      = sync2_reg[29:14];
    wire [15:0] out_c     = sync2_reg[45:30];

    // AXI4-Lite slave
    logic              awready_reg;
    logic              wready_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              arready_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;
    logic [7:0]        awaddr_reg;
    logic [7:0]        wdata_reg;
    logic              wstrb0_reg;
    fpl_pkg::fpl_ctrl_t ctrl_reg;
    fpl_pkg::fpl_irq_t  istat_reg;
    fpl_pkg::fpl_irq_t  imask_reg;
    fpl_pkg::fpl_irq_t  istat_next;
    fpl_pkg::fpl_state_t state_reg;
    logic              run_mode_reg;
    logic              dev_rst_seen_reg;
    logic [1:0]        wait_reg;

    wire aw_hs  = AWVALID_I & awready_reg;
    wire w_hs   = WVALID_I & wready_reg;
    wire ar_hs  = ARVALID_I & arready_reg;
    wire wr_do  = ~awready_reg & ~wready_reg & ~bvalid_reg;
    wire fpl_pkg::fpl_sel_t wsel = dec(awaddr_reg);
    wire fpl_pkg::fpl_sel_t rsel = dec(ARADDR_I);
    wire wr_lo  = wr_do & wstrb0_reg;
    wire wr_ctl = wr_lo & (wsel == fpl_pkg::FPL_SEL_CTRL);
    wire wr_cmd = wr_lo & (wsel == fpl_pkg::FPL_SEL_CMD);
    wire wr_ist = wr_lo & (wsel == fpl_pkg::FPL_SEL_ISTAT);
    wire wr_msk = wr_lo & (wsel == fpl_pkg::FPL_SEL_IMASK);
    wire [2:0] imask_next = wr_msk ? wdata_reg[2:0] : imask_reg;
    wire normal = (state_reg == fpl_pkg::FPL_ST_NORMAL);
    wire cmd_run  = wr_cmd & wdata_reg[`FPL_CMD_RUN_BIT];
    wire cmd_stop = wr_cmd & wdata_reg[`FPL_CMD_STOP_BIT] & ~cmd_run;
    wire [7:0] status_v = {2'h0, pwr_ok, disp_out, rstbit_sw, mode_sw,
                           dev_rst_seen_reg, run_mode_reg};
    logic [31:0] rd_v;
    always_comb
    begin
        unique case (rsel)
            fpl_pkg::FPL_SEL_CTRL:  rd_v = {24'h00_0000, ctrl_reg};
            fpl_pkg::FPL_SEL_STAT:  rd_v = {24'h00_0000, status_v};
            fpl_pkg::FPL_SEL_ISTAT: rd_v = {29'h0000_0000, istat_reg};
            fpl_pkg::FPL_SEL_IMASK: rd_v = {29'h0000_0000, imask_reg};
            default:                rd_v = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `FPL_RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= `FPL_RESP_OKAY;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 8'h00;
            wstrb0_reg  <= 1'b0;
        end
        else
        begin
            if (aw_hs)
            begin
                awaddr_reg  <= AWADDR_I;
                awready_reg <= 1'b0;
            end
            else if (wr_do)
                awready_reg <= 1'b1;
            if (w_hs)
            begin
                wdata_reg  <= WDATA_I[7:0];
                wstrb0_reg <= WSTRB_I[0];
                wready_reg <= 1'b0;
            end
            else if (wr_do)
                wready_reg <= 1'b1;
            if (wr_do)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= (wsel == fpl_pkg::FPL_SEL_NONE || wsel == fpl_pkg::FPL_SEL_STAT)
                              ? `FPL_RESP_DECERR : `FPL_RESP_OKAY;
            end
            else if (BREADY_I)
                bvalid_reg <= 1'b0;
            if (ar_hs)
            begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rdata_reg   <= rd_v;
                rresp_reg   <= (rsel == fpl_pkg::FPL_SEL_NONE) ? `FPL_RESP_DECERR
                                                               : `FPL_RESP_OKAY;
            end
            else if (rvalid_reg & RREADY_I)
            begin
                arready_reg <= 1'b1;
                rvalid_reg  <= 1'b0;
            end
        end
    end

    // Power-on sequencing and mode
    wire sample   = (state_reg == fpl_pkg::FPL_ST_WAIT) & (wait_reg == `FPL_SYNC_WAIT);
    wire do_init  = sample & ~mode_sw & rstbit_sw; // R3
    logic err_q_reg;
    fpl_pkg::fpl_irq_t ev;
    assign ev.mode_chg  = sample | (normal & (cmd_run | cmd_stop));
    assign ev.dev_reset = do_init;
    assign ev.err_rise  = ctrl_reg.sys_error & ~err_q_reg;
    assign istat_next   = (istat_reg & ~(wr_ist ? fpl_pkg::fpl_irq_t'(wdata_reg[2:0])
                                                : 3'h0)) | ev;

    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            state_reg        <= fpl_pkg::FPL_ST_WAIT;
            wait_reg         <= 2'h0;
            run_mode_reg     <= 1'b0;
            dev_rst_seen_reg <= 1'b0;
            ctrl_reg         <= `FPL_CTRL_RST;
            istat_reg        <= 3'h0;
            imask_reg        <= `FPL_MASK_RST;
            err_q_reg        <= 1'b0;
        end
        else
        begin
            err_q_reg <= ctrl_reg.sys_error;
            istat_reg <= istat_next;
            if (wr_ctl)
                ctrl_reg <= wdata_reg;
            imask_reg <= imask_next;
            unique case (state_reg)
                fpl_pkg::FPL_ST_WAIT:
                begin
                    wait_reg <= wait_reg + 2'h1;
                    if (sample)
                    begin
                        run_mode_reg <= mode_sw; // R1
                        state_reg    <= do_init ? fpl_pkg::FPL_ST_INIT
                                                : fpl_pkg::FPL_ST_NORMAL;
                    end
                end
                fpl_pkg::FPL_ST_INIT:
                begin
                    dev_rst_seen_reg <= 1'b1; // R3
                    state_reg        <= fpl_pkg::FPL_ST_NORMAL;
                end
                fpl_pkg::FPL_ST_NORMAL:
                begin
                    if (cmd_run)
                        run_mode_reg <= 1'b1; // R2
                    else if (cmd_stop)
                        run_mode_reg <= 1'b0; // R2
                end
            endcase
        end
    end

    // Blink base and activity stretchers
    logic [31:0] blink_cnt_reg;
    logic        blink_reg;
    logic [31:0] str_cnt_reg;
    wire         str_tick = (str_cnt_reg == STRETCH_CYC - 1);
    logic [2:0]  act_prev_reg;
    logic [2:0]  act_on;
    logic [2:0]  act_led;
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            blink_cnt_reg <= 32'h0000_0000;
            blink_reg     <= 1'b0;
            str_cnt_reg   <= 32'h0000_0000;
            act_prev_reg  <= act_lvl;
        end
        else
        begin
            blink_cnt_reg <= (blink_cnt_reg == BLINK_CYC - 1) ? 32'h0000_0000
                                                               : blink_cnt_reg + 32'h1;
            if (blink_cnt_reg == BLINK_CYC - 1)
                blink_reg <= ~blink_reg; // R7
            str_cnt_reg  <= str_tick ? 32'h0000_0000 : str_cnt_reg + 32'h1;
            act_prev_reg <= act_lvl;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_act
            logic [31:0] hold_reg;
            logic        led_reg;
            wire         seen = act_lvl[g] ^ act_prev_reg[g];
            always_ff @(posedge MCLK_I)
            begin
                if (RESET_I)
                begin
                    hold_reg <= 32'h0000_0000;
                    led_reg  <= 1'b0;
                end
                else
                begin
                    hold_reg <= seen ? 2 * STRETCH_CYC
                              : (hold_reg != 0) ? hold_reg - 32'h1 : hold_reg; // R15
                    if (str_tick)
                        led_reg <= ~led_reg & (hold_reg != 0); // R15
                end
            end
            assign act_on[g]  = (hold_reg != 0);
            assign act_led[g] = led_reg;
        end
    endgenerate

    // Indicator drive, all registered
    wire bus_oper  = (ctrl_reg.bus_state == fpl_pkg::FPL_BUS_OPER);
    wire bus_start = (ctrl_reg.bus_state == fpl_pkg::FPL_BUS_STARTUP);
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            POWER_LED_O                    <= 1'b0;
            ALARM_LED_O                    <= 1'b0;
            RUN_LED_O                      <= 1'b0;
            STOP_LED_O                     <= 1'b0;
            ERROR_LED_O                    <= 1'b0;
            CARD_ACCESS_INDICATOR_O        <= 1'b0;
            SERIAL_TX_INDICATOR_O          <= 1'b0;
            SERIAL_RX_INDICATOR_O          <= 1'b0;
            FIELDBUS_LINK_INDICATOR_O      <= 1'b0;
            PORT_LINK_ACTIVITY_INDICATOR_O <= 1'b0;
            CNT_PHASE_LED_O                <= 6'h00;
            CONTACT_LED_O                  <= 16'h0000;
            DEVICE_RESET_O                 <= 1'b0;
            IRQ_O                          <= 1'b0;
        end
        else
        begin
            POWER_LED_O <= pwr_ok & normal; // R4
            ALARM_LED_O <= ctrl_reg.sys_error; // R5
            RUN_LED_O   <= normal & ctrl_reg.app_loaded & run_mode_reg; // R6
            STOP_LED_O  <= normal & ctrl_reg.app_loaded & ~run_mode_reg; // R6
            ERROR_LED_O <= ctrl_reg.sys_error & blink_reg; // R7
            CARD_ACCESS_INDICATOR_O   <= ctrl_reg.card_busy; // R8
            SERIAL_TX_INDICATOR_O     <= act_led[0]; // R9
            SERIAL_RX_INDICATOR_O     <= act_led[1]; // R10
            FIELDBUS_LINK_INDICATOR_O <= bus_oper | (bus_start & blink_reg); // R11
            PORT_LINK_ACTIVITY_INDICATOR_O <= link_up & (act_on[2] | blink_reg); // R12
            CNT_PHASE_LED_O <= phase_s; // R13
            CONTACT_LED_O   <= disp_out ? out_c : in_c; // R14
            DEVICE_RESET_O  <= do_init; // R3
            IRQ_O           <= |(istat_next & imask_next);
        end
    end

    assign AWREADY_O = awready_reg;
    assign WREADY_O  = wready_reg;
    assign BVALID_O  = bvalid_reg;
    assign BRESP_O   = bresp_reg;
    assign ARREADY_O = arready_reg;
    assign RVALID_O  = rvalid_reg;
    assign RDATA_O   = rdata_reg;
    assign RRESP_O   = rresp_reg;

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);

    mode_at_start_a: assert property (sample |=> run_mode_reg == $past(mode_sw)) // R1
        else $error("Mode not taken from switch");
    remote_mode_a: assert property (normal && cmd_run |=> run_mode_reg) // R2
        else $error("Remote run ignored");
    dev_reset_a: assert property (do_init |=> DEVICE_RESET_O ##1 !DEVICE_RESET_O) // R3
        else $error("Device reset pulse wrong");
    power_lamp_a: assert property (!pwr_ok |=> !POWER_LED_O) // R4
        else $error("Power lamp lit without supply");
    alarm_lamp_a: assert property (ALARM_LED_O == $past(ctrl_reg.sys_error)) // R5
        else $error("Alarm lamp mismatch");
    run_stop_a: assert property (!(RUN_LED_O && STOP_LED_O)) // R6
        else $error("Run and stop both lit");
    error_off_a: assert property (!ctrl_reg.sys_error |=> !ERROR_LED_O) // R7
        else $error("Error lamp lit without error");
    card_lamp_a: assert property (ctrl_reg.card_busy |=> CARD_ACCESS_INDICATOR_O) // R8
        else $error("Card lamp dark during access");
    serial_idle_a: assert property (!act_on[0] && !act_led[0] |=> !SERIAL_TX_INDICATOR_O) // R9
        else $error("Transmit lamp lit while idle");
    port_dark_a: assert property (!link_up |=> !PORT_LINK_ACTIVITY_INDICATOR_O) // R12
        else $error("Port lamp lit without link");
    contact_sel_a: assert property (disp_out |=> CONTACT_LED_O == $past(out_c)) // R14
        else $error("Contact display wrong source");
    irq_level_a: assert property (IRQ_O == |(istat_reg & imask_reg))
        else $error("Interrupt not raised");

    init_seen_c: cover property (do_init ##1 DEVICE_RESET_O);
    remote_stop_c: cover property (normal && cmd_stop);
    read_ok_c: cover property (rvalid_reg && RREADY_I);
    write_ok_c: cover property (bvalid_reg && BREADY_I);
endmodule

// ### bench/fpl_panel_model.sv
// Far side model: serial lines and port traffic source of the front panel
`timescale 1ns/1ps
module fpl_panel_model (
    input  wire logic clk_i,
    input  wire logic tx_act_i,
    input  wire logic rx_act_i,
    input  wire logic traffic_act_i,
    output logic      ser_tx_o,
    output logic      ser_rx_o,
    output logic      phy_traffic_o
);
    initial
    begin
        ser_tx_o      = 1'b1;
        ser_rx_o      = 1'b1;
        phy_traffic_o = 1'b0;
    end

    always @(posedge clk_i)
    begin
        ser_tx_o      <= tx_act_i ? ~ser_tx_o : 1'b1;
        ser_rx_o      <= rx_act_i ? ~ser_rx_o : 1'b1;
        phy_traffic_o <= phy_traffic_o ^ traffic_act_i;
    end
endmodule

// ### bench/tb_top.sv
// Self-checking bench of the front panel logic
`timescale 1ns/1ps
`include "fpl_regs.svh"
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end
module tb_top;
    logic        MCLK_I = 1'b0, RESET_I = 1'b1;
    logic [7:0]  AWADDR_I = 8'h00, ARADDR_I = 8'h00;
    logic [31:0] WDATA_I = 32'h0000_0000;
    logic [3:0]  WSTRB_I = 4'hF;
    logic        AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0;
    logic        ARVALID_I = 1'b0, RREADY_I = 1'b0;
    logic        MODE_RUN_SW_I = 1'b0, RESET_BIT_SWITCH_I = 1'b1, DISP_SEL_OUT_I = 1'b0;
    logic        POWER_GOOD_I = 1'b1, PHYSICAL_LINK_UP_I = 1'b0;
    logic [5:0]  CNT_PHASE_I = 6'h00;
    logic [15:0] INPUT_CONTACTS_I = 16'h0000, OUTPUT_CONTACTS_I = 16'h0000;
    logic        tx_act = 1'b0, rx_act = 1'b0, traffic_act = 1'b0;
    wire         SER_TX_I, SER_RX_I, PHY_TRAFFIC_I;
    wire         AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, IRQ_O, DEVICE_RESET_O;
    wire  [1:0]  BRESP_O, RRESP_O;
    wire  [31:0] RDATA_O;
    wire         POWER_LED_O, ALARM_LED_O, RUN_LED_O, STOP_LED_O, ERROR_LED_O;
    wire         CARD_ACCESS_INDICATOR_O, SERIAL_TX_INDICATOR_O, SERIAL_RX_INDICATOR_O;
    wire         FIELDBUS_LINK_INDICATOR_O, PORT_LINK_ACTIVITY_INDICATOR_O;
    wire  [5:0]  CNT_PHASE_LED_O;
    wire  [15:0] CONTACT_LED_O;
    wire  [4:0]  lamps = {ERROR_LED_O, FIELDBUS_LINK_INDICATOR_O,
                          PORT_LINK_ACTIVITY_INDICATOR_O, SERIAL_TX_INDICATOR_O,
                          SERIAL_RX_INDICATOR_O};
    int          n_mismatch = 0, cmp_count = 0, n_devrst = 0;
    int          hi [5];
    logic [1:0]  resp;
    logic [31:0] rd;

    fpl_front_panel #(.BLINK_CYC(8), .STRETCH_CYC(4)) uut (
        .MCLK_I(MCLK_I), .RESET_I(RESET_I), .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I),
        .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I),
        .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
        .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
        .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
        .MODE_RUN_SW_I(MODE_RUN_SW_I), .RESET_BIT_SWITCH_I(RESET_BIT_SWITCH_I),
        .DISP_SEL_OUT_I(DISP_SEL_OUT_I), .POWER_GOOD_I(POWER_GOOD_I), .SER_TX_I(SER_TX_I),
        .SER_RX_I(SER_RX_I), .PHYSICAL_LINK_UP_I(PHYSICAL_LINK_UP_I),
        .PHY_TRAFFIC_I(PHY_TRAFFIC_I), .CNT_PHASE_I(CNT_PHASE_I),
        .INPUT_CONTACTS_I(INPUT_CONTACTS_I), .OUTPUT_CONTACTS_I(OUTPUT_CONTACTS_I),
        .POWER_LED_O(POWER_LED_O), .ALARM_LED_O(ALARM_LED_O), .RUN_LED_O(RUN_LED_O),
        .STOP_LED_O(STOP_LED_O), .ERROR_LED_O(ERROR_LED_O),
        .CARD_ACCESS_INDICATOR_O(CARD_ACCESS_INDICATOR_O),
        .SERIAL_TX_INDICATOR_O(SERIAL_TX_INDICATOR_O),
        .SERIAL_RX_INDICATOR_O(SERIAL_RX_INDICATOR_O),
        .FIELDBUS_LINK_INDICATOR_O(FIELDBUS_LINK_INDICATOR_O),
        .PORT_LINK_ACTIVITY_INDICATOR_O(PORT_LINK_ACTIVITY_INDICATOR_O),
        .CNT_PHASE_LED_O(CNT_PHASE_LED_O), .CONTACT_LED_O(CONTACT_LED_O),
        .DEVICE_RESET_O(DEVICE_RESET_O), .IRQ_O(IRQ_O)
    );

    fpl_panel_model model (
        .clk_i(MCLK_I), .tx_act_i(tx_act), .rx_act_i(rx_act), .traffic_act_i(traffic_act),
        .ser_tx_o(SER_TX_I), .ser_rx_o(SER_RX_I), .phy_traffic_o(PHY_TRAFFIC_I)
    );

    always #12.5 MCLK_I = ~MCLK_I;

    always @(negedge MCLK_I)
        n_devrst = RESET_I ? 0 : n_devrst + (DEVICE_RESET_O === 1'b1);

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n)
            @(negedge MCLK_I);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        @(posedge MCLK_I);
        AWADDR_I  <= a;
        WDATA_I   <= d;
        AWVALID_I <= 1'b1;
        WVALID_I  <= 1'b1;
        BREADY_I  <= 1'b1;
        b_t = 1'b0;
        for (int n = 0; n < 64 && !b_t; n++)
        begin
            @(negedge MCLK_I);
            aw_t = AWVALID_I && (AWREADY_O === 1'b1);
            w_t  = WVALID_I && (WREADY_O === 1'b1);
            b_t  = BVALID_O === 1'b1;
            resp = BRESP_O;
            @(posedge MCLK_I);
            if (aw_t)
                AWVALID_I <= 1'b0;
            if (w_t)
                WVALID_I <= 1'b0;
        end
        BREADY_I <= 1'b0;
        if (!b_t)
            n_mismatch++;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ar_t, r_t;
        @(posedge MCLK_I);
        ARADDR_I  <= a;
        ARVALID_I <= 1'b1;
        RREADY_I  <= 1'b1;
        r_t = 1'b0;
        for (int n = 0; n < 64 && !r_t; n++)
        begin
            @(negedge MCLK_I);
            ar_t = ARVALID_I && (ARREADY_O === 1'b1);
            r_t  = RVALID_O === 1'b1;
            rd   = RDATA_O;
            resp = RRESP_O;
            @(posedge MCLK_I);
            if (ar_t)
                ARVALID_I <= 1'b0;
        end
        RREADY_I <= 1'b0;
        `CHK(r_t, 1'b1)
        `CHK(rd, e)
        `CHK(resp, er)
    endtask

    task automatic measure(input int n);
        hi = '{default: 0};
        repeat (n)
        begin
            @(negedge MCLK_I);
            for (int i = 0; i < 5; i++)
                hi[i] += lamps[i];
        end
    endtask

    task automatic power_on(input logic run_sw);
        @(posedge MCLK_I);
        RESET_I       <= 1'b1;
        MODE_RUN_SW_I <= run_sw;
        repeat (3)
            @(posedge MCLK_I);
        RESET_I <= 1'b0;
        wait_n(12);
    endtask

    task automatic wr_wait(input logic [7:0] a, input logic [31:0] d);
        axi_wr(a, d);
        wait_n(4);
    endtask

    initial
    begin
        #(25 * 20000);
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        power_on(1'b0);
        `CHK(n_devrst, 1)
        rd_chk(`FPL_OFS_STATUS, 32'h0000_002A, `FPL_RESP_OKAY);
        `CHK(POWER_LED_O, 1'b1)
        `CHK({RUN_LED_O, STOP_LED_O}, 2'b00)
        rd_chk(`FPL_OFS_INT_STAT, 32'h0000_0003, `FPL_RESP_OKAY);
        `CHK(IRQ_O, 1'b0)
        wr_wait(`FPL_OFS_INT_MASK, 32'h0000_0001);
        `CHK(IRQ_O, 1'b1)
        wr_wait(`FPL_OFS_INT_STAT, 32'h0000_0003);
        `CHK(IRQ_O, 1'b0)
        rd_chk(`FPL_OFS_INT_STAT, 32'h0000_0000, `FPL_RESP_OKAY);
        axi_wr(`FPL_OFS_INT_MASK, 32'h0000_0004);
        rd_chk(`FPL_OFS_INT_MASK, 32'h0000_0004, `FPL_RESP_OKAY);
        wr_wait(`FPL_OFS_CTRL, 32'h0000_0001);
        `CHK(resp, `FPL_RESP_OKAY)
        `CHK({RUN_LED_O, STOP_LED_O}, 2'b01)
        wr_wait(`FPL_OFS_CMD, 32'h0000_0001);
        `CHK({RUN_LED_O, STOP_LED_O}, 2'b10)
        rd_chk(`FPL_OFS_STATUS, 32'h0000_002B, `FPL_RESP_OKAY);
        wr_wait(`FPL_OFS_CMD, 32'h0000_0002);
        `CHK({RUN_LED_O, STOP_LED_O}, 2'b01)
        wr_wait(`FPL_OFS_CMD, 32'h0000_0003);
        `CHK({RUN_LED_O, STOP_LED_O}, 2'b10)
        rd_chk(`FPL_OFS_CMD, 32'h0000_0000, `FPL_RESP_OKAY);
        wr_wait(`FPL_OFS_CTRL, 32'h0000_0003);
        `CHK({ALARM_LED_O, IRQ_O}, 2'b11)
        measure(64);
        `CHK(hi[4], 32)
        wr_wait(`FPL_OFS_CTRL, 32'h0000_0001);
        `CHK({ALARM_LED_O, ERROR_LED_O}, 2'b00)
        wr_wait(`FPL_OFS_CTRL, 32'h0000_0005);
        `CHK(CARD_ACCESS_INDICATOR_O, 1'b1)
        wr_wait(`FPL_OFS_CTRL, 32'h0000_0001);
        `CHK(CARD_ACCESS_INDICATOR_O, 1'b0)
        for (int s = 0; s < 3; s++)
        begin
            wr_wait(`FPL_OFS_CTRL, 32'h0000_0001 | (32'(s) << 3));
            measure(64);
            `CHK(hi[3], 32 * s)
        end
        @(posedge MCLK_I);
        {tx_act, rx_act} <= 2'b11;
        wait_n(16);
        measure(64);
        `CHK(hi[1], 32)
        `CHK(hi[0], 32)
        @(posedge MCLK_I);
        {tx_act, rx_act} <= 2'b00;
        wait_n(24);
        measure(16);
        `CHK(hi[1] + hi[0], 0)
        @(posedge MCLK_I);
        PHYSICAL_LINK_UP_I <= 1'b1;
        wait_n(8);
        measure(64);
        `CHK(hi[2] > 0 && hi[2] < 64, 1'b1)
        @(posedge MCLK_I);
        traffic_act <= 1'b1;
        wait_n(8);
        measure(64);
        `CHK(hi[2], 64)
        @(posedge MCLK_I);
        {PHYSICAL_LINK_UP_I, traffic_act} <= 2'b00;
        wait_n(24);
        measure(16);
        `CHK(hi[2], 0)
        for (int k = 0; k < 2; k++)
        begin
            @(posedge MCLK_I);
            CNT_PHASE_I       <= k ? 6'h15 : 6'h2A;
            INPUT_CONTACTS_I  <= k ? 16'h5AA5 : 16'h1234;
            OUTPUT_CONTACTS_I <= k ? 16'hC3F0 : 16'hABCD;
            DISP_SEL_OUT_I    <= k[0];
            wait_n(4);
            `CHK(CNT_PHASE_LED_O, CNT_PHASE_I)
            `CHK(CONTACT_LED_O, k ? OUTPUT_CONTACTS_I : INPUT_CONTACTS_I)
        end
        rd_chk(8'h14, 32'h0000_0000, `FPL_RESP_DECERR);
        axi_wr(`FPL_OFS_STATUS, 32'h0000_0000);
        `CHK(resp, `FPL_RESP_DECERR)
        @(posedge MCLK_I);
        POWER_GOOD_I <= 1'b0;
        wait_n(4);
        `CHK(POWER_LED_O, 1'b0)
        @(posedge MCLK_I);
        POWER_GOOD_I <= 1'b1;
        power_on(1'b1);
        `CHK(n_devrst, 0)
        rd_chk(`FPL_OFS_STATUS, 32'h0000_003D, `FPL_RESP_OKAY);
        wrap_up();
    end
endmodule
